// File: design/wit_prescaler.sv
// free-running prescaler giving one-cycle count enables for all eight taps
`timescale 1ns/1ns
`include "wit_regs.svh"
module wit_prescaler
  import wit_pkg::*;
(
  input wire logic clk_sys, // system clock
  input wire logic srst, // sync reset
  output logic [7:0] tick_q // one pulse per tap period
);
  // log2 of divisors 2,32,64,128,256,512,2048,4096
  localparam int TAP_EXP [8] = '{1, 5, 6, 7, 8, 9, 11, 12};

  logic [`WIT_PRE_W-1:0] pre_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 12'h001;
    end
  end

  for (genvar g = 0; g < 8; g++) begin : g_tap
    localparam logic [`WIT_PRE_W-1:0] MASK = `WIT_PRE_W'((1 << TAP_EXP[g]) - 1);
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        tick_q[g] <= 1'b0;
      end else begin
        tick_q[g] <= ((pre_q & MASK) == MASK);
      end
    end
  end
endmodule

// File: design/wit_top.sv
// watchdog / interval timer with password-protected registers
// Functional notes
// - 8-bit up-counter, one step per tap pulse
// - interval overflow sets overflow flag
// - watchdog overflow leaves overflow flag alone
// - flag clears by read-set then write zero
// - run bit off holds counter at zero
// - mode bit picks interrupt or chip reset
// - every interval overflow raises interrupt request
// - select code picks divide 2 to 4096
// - standby clears top bits, soft keeps select
// - reserved bits ignore writes, read one
// - watchdog overflow resets chip, sets flag
// - output enable drives reset pin low
// - reset pin or read-write-zero clears flag
// - output enable survives watchdog reset and standby
// - counter and control written by word only
// - shared write address, key picks register
// - reset status written by word only
// - key A5 with zero clears watchdog flag
// - key 5A loads output enable bit
// - byte reads at three read addresses
// - reset pin pulse lasts 132 cycles
// - counter write beats coincident count step
`timescale 1ns/1ns
`include "wit_regs.svh"
module wit_top
  import wit_pkg::*;
(
  input wire logic clk_sys, // 25 MHz system clock
  input wire logic srst, // sync power-on reset
  input wit_bus_req_t bus, // cpu register access
  input wire logic stby_sw, // software standby
  input wire logic stby_hw, // hardware standby
  input wire logic res_n_in, // reset pin level
  output logic res_n_out_q, // reset pin drive level
  output logic res_n_oe_q, // reset pin drive enable
  output logic [7:0] rdata_q, // read data
  output logic irq_q, // interval request pulse
  output logic chip_rst_q // internal chip reset
);
  logic [7:0] tick;
  logic [7:0] cnt_q;
  logic flag_q, mode_q, run_q;
  wit_cks_t cks_q;
  logic wd_reset_flag_q, oe_q;
  logic flag_arm_q, wd_reset_flag_arm_q;
  logic res_s1_q, res_s2_q;
  logic [7:0] hold_q;
  wit_rst_st_t st_q;
  logic [7:0] key, dat;
  logic wr_w, cnt_wr, tcs_wr, oe_wr, clr_wr;
  logic step, ovf_ev, wd_ev, int_ev, ext_rst, wd_rst;

  wit_prescaler u_pre (
    .clk_sys(clk_sys),
    .srst(srst),
    .tick_q(tick)
  );

  // pin level crosses in through two flops
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      res_s1_q <= 1'b1;
      res_s2_q <= 1'b1;
    end else begin
      res_s1_q <= res_n_in;
      res_s2_q <= res_s1_q;
    end
  end

  assign key = bus.wdata[15:8];
  assign dat = bus.wdata[7:0];
  assign wr_w = bus.wr && bus.word;
  assign cnt_wr = wr_w && bus.addr == `WIT_ADDR_TCS_WR && key == `WIT_KEY_CNT;
  assign tcs_wr = wr_w && bus.addr == `WIT_ADDR_TCS_WR && key == `WIT_KEY_TCS;
  assign oe_wr = wr_w && bus.addr == `WIT_ADDR_RCS_WR && key == `WIT_KEY_RCS_OE;
  assign clr_wr = wr_w && bus.addr == `WIT_ADDR_RCS_WR && key == `WIT_KEY_RCS_CLR
    && dat == `WIT_RCS_CLR_DATA;

  // own drive is still in the synchroniser while settling, so ignore it
  assign ext_rst = !res_s2_q && st_q == WIT_IDLE;
  assign wd_rst = st_q != WIT_IDLE;
  assign step = run_q && tick[cks_q] && !cnt_wr;
  assign ovf_ev = step && cnt_q == `WIT_CNT_MAX && !wd_rst;
  assign wd_ev = ovf_ev && mode_q;
  assign int_ev = ovf_ev && !mode_q;

  always_ff @(posedge clk_sys) begin
    if (srst || ext_rst || wd_rst || stby_sw || stby_hw) begin
      cnt_q <= `WIT_CNT_RST;
    end else if (!run_q) begin
      cnt_q <= `WIT_CNT_RST;
    end else if (cnt_wr) begin
      cnt_q <= dat;
    end else if (step) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || ext_rst || wd_rst || stby_hw) begin
      {flag_q, mode_q, run_q} <= 3'h0;
      cks_q <= 3'h0;
    end else if (stby_sw) begin
      {flag_q, mode_q, run_q} <= 3'h0;
    end else begin
      if (tcs_wr) begin
        mode_q <= dat[`WIT_BIT_MODE];
        run_q <= dat[`WIT_BIT_RUN];
        cks_q <= dat[`WIT_CKS_MSB:0];
      end
      // set beats a clear in the same cycle
      if (int_ev) begin
        flag_q <= 1'b1;
      end else if (tcs_wr && flag_arm_q && !dat[`WIT_BIT_FLAG]) begin
        flag_q <= 1'b0;
      end
    end
  end

  // read of a set flag arms the later write of zero
  always_ff @(posedge clk_sys) begin
    if (srst || ext_rst || wd_rst || stby_hw || stby_sw) begin
      flag_arm_q <= 1'b0;
    end else if (tcs_wr) begin
      flag_arm_q <= 1'b0;
    end else if (bus.rd && bus.addr == `WIT_ADDR_TCS_RD && flag_q) begin
      flag_arm_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || ext_rst) begin
      wd_reset_flag_q <= 1'b0;
      oe_q <= 1'b0;
      wd_reset_flag_arm_q <= 1'b0;
    end else begin
      if (oe_wr) begin
        oe_q <= dat[`WIT_BIT_OE];
      end
      if (wd_ev) begin
        wd_reset_flag_q <= 1'b1;
      end else if (clr_wr && wd_reset_flag_arm_q) begin
        wd_reset_flag_q <= 1'b0;
      end
      if (clr_wr || wd_ev) begin
        wd_reset_flag_arm_q <= 1'b0;
      end else if (bus.rd && bus.addr == `WIT_ADDR_RCS_RD && wd_reset_flag_q) begin
        wd_reset_flag_arm_q <= 1'b1;
      end
    end
  end

  // internal reset runs a little past the pin pulse
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_q <= WIT_IDLE;
      hold_q <= 8'h00;
      chip_rst_q <= 1'b0;
      res_n_oe_q <= 1'b0;
    end else begin
      unique case (st_q)
        WIT_IDLE: begin
          if (wd_ev) begin
            st_q <= WIT_DRIVE;
            hold_q <= 8'(`WIT_PIN_PULSE_CYC - 1);
            chip_rst_q <= 1'b1;
            res_n_oe_q <= oe_q;
          end
        end
        WIT_DRIVE: begin
          if (hold_q == 8'h00) begin
            st_q <= WIT_SETTLE;
            hold_q <= 8'(`WIT_SYNC_SLACK - 1);
            res_n_oe_q <= 1'b0;
          end else begin
            hold_q <= hold_q - 8'h01;
          end
        end
        WIT_SETTLE: begin
          if (hold_q == 8'h00) begin
            st_q <= WIT_IDLE;
            chip_rst_q <= 1'b0;
          end else begin
            hold_q <= hold_q - 8'h01;
          end
        end
        default: begin
          st_q <= WIT_IDLE;
        end
      endcase
    end
  end

  // pin is only ever pulled low
  always_ff @(posedge clk_sys) begin
    res_n_out_q <= 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= int_ev;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_q <= `WIT_RD_NONE;
    end else if (bus.rd) begin
      unique case (bus.addr)
        `WIT_ADDR_TCS_RD: rdata_q <= {flag_q, mode_q, run_q, 2'b00, cks_q} | `WIT_TCS_RSV;
        `WIT_ADDR_CNT_RD: rdata_q <= cnt_q;
        `WIT_ADDR_RCS_RD: rdata_q <= {wd_reset_flag_q, oe_q, 6'h00} | `WIT_RCS_RSV;
        default: rdata_q <= `WIT_RD_NONE;
      endcase
    end
  end

  // helper: length of each pin drive
  logic [8:0] oe_len_q;
  always_ff @(posedge clk_sys) begin
    if (srst || !res_n_oe_q) begin
      oe_len_q <= 9'h000;
    end else begin
      oe_len_q <= oe_len_q + 9'h001;
    end
  end

  property p_run_off;
    @(posedge clk_sys) disable iff (srst) !run_q |=> cnt_q == 8'h00;
  endproperty
  a_run_off: assert property (p_run_off) else $error("counter not held at zero");

  property p_step;
    @(posedge clk_sys) disable iff (srst)
      step && !wd_rst && !stby_sw && !stby_hw && !ext_rst |=> cnt_q == 8'($past(cnt_q) + 8'h01);
  endproperty
  a_step: assert property (p_step) else $error("counter missed a step");

  // a write landing with a count pulse keeps the written value
  property p_cnt_wr;
    @(posedge clk_sys) disable iff (srst)
      cnt_wr && run_q && !wd_rst && !stby_sw && !stby_hw && !ext_rst |=> cnt_q == $past(dat);
  endproperty
  a_cnt_wr: assert property (p_cnt_wr) else $error("counter write lost");

  property p_int_ovf;
    @(posedge clk_sys) disable iff (srst)
      run_q && !mode_q && cnt_q == 8'hFF && tick[cks_q] && !cnt_wr && !wd_rst |=> irq_q ##1 !irq_q;
  endproperty
  a_int_ovf: assert property (p_int_ovf) else $error("interval request missing");

  property p_flag_set;
    @(posedge clk_sys) disable iff (srst)
      int_ev && !stby_sw && !stby_hw && !ext_rst |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_flag_wd;
    @(posedge clk_sys) disable iff (srst) !flag_q && wd_ev |=> !flag_q;
  endproperty
  a_flag_wd: assert property (p_flag_wd) else $error("flag set in watchdog mode");

  property p_wd_rst;
    @(posedge clk_sys) disable iff (srst)
      wd_ev && !ext_rst |=> wd_reset_flag_q && chip_rst_q && res_n_oe_q == $past(oe_q) && oe_q == $past(oe_q);
  endproperty
  a_wd_rst: assert property (p_wd_rst) else $error("watchdog reset wrong");

  property p_pin_len;
    @(posedge clk_sys) disable iff (srst) $fell(res_n_oe_q) |-> oe_len_q == 9'h084;
  endproperty
  a_pin_len: assert property (p_pin_len) else $error("pin pulse length wrong");

  property p_byte_wr;
    @(posedge clk_sys) disable iff (srst)
      bus.wr && !bus.word && !wd_rst && !wd_ev && !ext_rst && !stby_sw && !stby_hw
      |=> $stable({mode_q, run_q, cks_q, oe_q});
  endproperty
  a_byte_wr: assert property (p_byte_wr) else $error("byte write took effect");

  property p_w1_flag;
    @(posedge clk_sys) disable iff (srst) !wd_reset_flag_q && !wd_ev |=> !wd_reset_flag_q;
  endproperty
  a_w1_flag: assert property (p_w1_flag) else $error("watchdog flag set by software");

  property p_rd_cnt;
    @(posedge clk_sys) disable iff (srst) bus.rd && bus.addr == 16'hFF11 |=> rdata_q == $past(cnt_q);
  endproperty
  a_rd_cnt: assert property (p_rd_cnt) else $error("counter read wrong");

  c_int: cover property (@(posedge clk_sys) disable iff (srst) int_ev);
  c_wd: cover property (@(posedge clk_sys) disable iff (srst) wd_ev && oe_q);
  c_clr: cover property (@(posedge clk_sys) disable iff (srst) wd_reset_flag_q ##1 !wd_reset_flag_q);
  c_flag_clr: cover property (@(posedge clk_sys) disable iff (srst) flag_q ##[1:20] !flag_q);
endmodule

// File: pkg/wit_pkg.sv
// types shared by the watchdog / interval timer
package wit_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
    logic word;
  } wit_bus_req_t;
  typedef logic [2:0] wit_cks_t;
  typedef enum logic [1:0] {
    WIT_IDLE = 2'b00,
    WIT_DRIVE = 2'b01,
    WIT_SETTLE = 2'b11
  } wit_rst_st_t;
endpackage

// File: pkg/wit_regs.svh
// register map, field positions, reset values and timing counts
`ifndef WIT_REGS_SVH
`define WIT_REGS_SVH
`define WIT_ADDR_TCS_WR 16'hFF10
`define WIT_ADDR_TCS_RD 16'hFF10
`define WIT_ADDR_CNT_RD 16'hFF11
`define WIT_ADDR_RCS_WR 16'hFF1E
`define WIT_ADDR_RCS_RD 16'hFF1F
`define WIT_KEY_CNT 8'h5A
`define WIT_KEY_TCS 8'hA5
`define WIT_KEY_RCS_OE 8'h5A
`define WIT_KEY_RCS_CLR 8'hA5
`define WIT_RCS_CLR_DATA 8'h00
`define WIT_BIT_FLAG 7
`define WIT_BIT_MODE 6
`define WIT_BIT_RUN 5
`define WIT_BIT_OE 6
`define WIT_CKS_MSB 2
`define WIT_TCS_RSV 8'h18
`define WIT_RCS_RSV 8'h3F
`define WIT_TCS_RST 8'h18
`define WIT_CNT_RST 8'h00
`define WIT_RCS_RST 8'h3F
`define WIT_CNT_MAX 8'hFF
`define WIT_RD_NONE 8'h00
`define WIT_PIN_PULSE_CYC 132
`define WIT_SYNC_SLACK 4
`define WIT_RST_HOLD (`WIT_PIN_PULSE_CYC + `WIT_SYNC_SLACK)
`define WIT_PRE_W 12
`endif

// File: verif/tb.sv
// self-checking bench for the watchdog / interval timer
`timescale 1ns/1ns
module tb
  import wit_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  wit_bus_req_t bus = '0;
  logic stby_sw = 1'b0;
  logic stby_hw = 1'b0;
  logic ext_low = 1'b0;
  logic res_n_in;
  logic res_n_out_q;
  logic res_n_oe_q;
  logic irq_q;
  logic chip_rst_q;
  logic [7:0] rdata_q;
  logic [9:0] n;
  logic [3:0] c;
  int err_total = 0;
  int checks_done = 0;

  always #20 clk_sys = ~clk_sys;

  wit_top wit_top_i (.clk_sys(clk_sys), .srst(srst), .bus(bus), .stby_sw(stby_sw), .stby_hw(stby_hw),
    .res_n_in(res_n_in), .res_n_out_q(res_n_out_q), .res_n_oe_q(res_n_oe_q), .rdata_q(rdata_q),
    .irq_q(irq_q), .chip_rst_q(chip_rst_q));
  wit_pin_model wit_pin_model_i (.res_n_out_q(res_n_out_q), .res_n_oe_q(res_n_oe_q), .ext_low(ext_low),
    .res_n_in(res_n_in));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic step;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0, word: w};
    @(posedge clk_sys);
    bus <= '0;
  endtask

  // rdata_q lands at the edge that takes the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1, word: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    chk($sformatf("read %h", a), {8'h00, e}, {8'h00, rdata_q});
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    results;
  end

  initial begin
    // pin synchroniser resets high, so two edges are enough
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rd(16'hFF10, 8'h18);
    rd(16'hFF11, 8'h00);
    rd(16'hFF1F, 8'h3F);
    rd(16'hFF12, 8'h00);
    $display("test reset values done");

    for (c = 4'h0; c < 4'h8; c++) begin
      wr(16'hFF10, {8'hA5, 5'b11000, c[2:0]}, 1'b1);
      rd(16'hFF10, {5'b01011, c[2:0]});
    end
    wr(16'hFF10, 16'hA525, 1'b1);
    @(posedge clk_sys);
    stby_sw <= 1'b1;
    @(posedge clk_sys);
    stby_sw <= 1'b0;
    rd(16'hFF10, 8'h1D);
    @(posedge clk_sys);
    stby_hw <= 1'b1;
    @(posedge clk_sys);
    stby_hw <= 1'b0;
    rd(16'hFF10, 8'h18);
    $display("test control fields done");

    wr(16'hFF10, 16'hA520, 1'b1);
    wr(16'hFF10, 16'h5AFE, 1'b1);
    n = 10'h000;
    while (irq_q !== 1'b1 && n < 10'h014) begin
      step;
      n++;
    end
    n = 10'h001;
    step;
    while (irq_q !== 1'b1 && n < 10'h3E8) begin
      step;
      n++;
    end
    chk("irq spacing", 16'h0200, {6'h00, n});
    rd(16'hFF10, 8'hB8);
    wr(16'hFF10, 16'hA520, 1'b1);
    rd(16'hFF10, 8'h38);
    wr(16'hFF10, 16'hA5A0, 1'b1);
    wr(16'hFF10, 16'hA540, 1'b0);
    wr(16'hFF10, 16'h3340, 1'b1);
    rd(16'hFF10, 8'h38);
    wr(16'hFF10, 16'hA500, 1'b1);
    rd(16'hFF11, 8'h00);
    wr(16'hFF10, 16'hA527, 1'b1);
    wr(16'hFF10, 16'h5A10, 1'b1);
    rd(16'hFF11, 8'h10);
    $display("test interval done");

    wr(16'hFF1E, 16'h5A40, 1'b1);
    wr(16'hFF1E, 16'h5A00, 1'b0);
    rd(16'hFF1F, 8'h7F);
    wr(16'hFF10, 16'hA560, 1'b1);
    n = 10'h000;
    while (chip_rst_q !== 1'b1 && n < 10'h3E8) begin
      step;
      n++;
    end
    chk("pin level", 16'h0000, {15'h0000, res_n_in});
    chk("chip reset", 16'h0001, {15'h0000, chip_rst_q});
    n = 10'h000;
    while (res_n_oe_q === 1'b1 && n < 10'h12C) begin
      step;
      n++;
    end
    chk("pin pulse", 16'h0084, {6'h00, n});
    n = 10'h000;
    while (chip_rst_q === 1'b1 && n < 10'h014) begin
      step;
      n++;
    end
    chk("chip reset tail", 16'h0004, {6'h00, n});
    rd(16'hFF1F, 8'hFF);
    rd(16'hFF10, 8'h18);
    wr(16'hFF1E, 16'hA500, 1'b1);
    rd(16'hFF1F, 8'h7F);
    @(posedge clk_sys);
    ext_low <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ext_low <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rd(16'hFF1F, 8'h3F);
    $display("test watchdog done");
    results;
  end
endmodule

// File: verif/wit_pin_model.sv
// far side of the reset pin: pull-up plus an outside device that can pull it low
`timescale 1ns/1ns
module wit_pin_model (
  input wire logic res_n_out_q, // device drive value
  input wire logic res_n_oe_q, // device drive enable
  input wire logic ext_low, // outside device pulls low
  output logic res_n_in // resolved pin level
);
  // released pin floats to the pull-up level, any low driver wins
  assign res_n_in = !ext_low && !(res_n_oe_q && !res_n_out_q);
endmodule
